// ==== logic/wdg_pkg.sv ====
// Purpose: Shared constants, types and lookup functions for the watchdog.
// Assumes: One 125 MHz clock; osc_tick marks one divided oscillator cycle.
// Notes: All offsets, bit positions and timing figures live here.
package wdg_pkg;

    // Register map on the plain register port
    localparam logic [7:0] CTRL_ADDR = 8'h2a;
    localparam logic [7:0] STATUS_ADDR = 8'h2b;
    localparam logic [7:0] CTRL_RESET = 8'h7f;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Control register fields
    localparam int ACT_BIT = 7;
    localparam int TOP_BIT = 6;
    localparam int COUNT_W = 7;

    // Counter value whose decrement clears the top bit
    localparam logic [6:0] ROLL_VALUE = 7'h40;
    localparam logic [6:0] COUNT_ONE = 7'h01;

    // Status register fields
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_STOPPED_BIT = 1;
    localparam int ST_RESTART_BIT = 2;
    localparam int ST_PULSE_BIT = 3;
    localparam int ST_HW_BIT = 4;

    // Decrement prescaler, in divided oscillator cycles
    localparam int TICKS_PER_DEC = 16384;
    localparam int PRESC_W = 14;
    localparam int TICK_UNIT = 64;
    localparam int MIN_BASE = 128;
    localparam int SHORT_BASE = 192;
    localparam int SLOT_W = 4;

    // Reset pulse: a least time, so it rounds up
    localparam int CLK_NS = 8;
    localparam int RST_PULSE_NS = 500;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_W = 6;

    // Restart delay after wake from plain halt, in CPU clocks
    localparam int RESTART_SHORT = 256;
    localparam int RESTART_LONG = 4096;
    localparam int RESTART_W = 13;

    // Straps and clock controller bits seen by the watchdog
    typedef struct packed {
        logic hw_watchdog_option;
        logic halt_reset_option;
        logic rtc_interrupt_enable;
        logic [1:0] rtc_timebase_select;
        logic long_restart;
    } wdg_cfg_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_STOPPED = 3'b010,
        ST_RESTART = 3'b100
    } halt_state_t;

    // High timing constant of each timebase
    function automatic int tb_hi(input logic [1:0] tb);
        case (tb)
            2'h0: tb_hi = 4;
            2'h1: tb_hi = 8;
            2'h2: tb_hi = 20;
            default: tb_hi = 49;
        endcase
    endfunction : tb_hi

    // Low timing constant of each timebase
    function automatic int tb_lo(input logic [1:0] tb);
        case (tb)
            2'h0: tb_lo = 59;
            2'h1: tb_lo = 53;
            2'h2: tb_lo = 35;
            default: tb_lo = 54;
        endcase
    endfunction : tb_lo

endpackage : wdg_pkg

// ==== logic/wdg_prescaler.sv ====
// Purpose: Decrement prescaler of the watchdog counter.
// Assumes: osc_tick is a one-cycle pulse per divided oscillator cycle.
// Notes: Never cleared by register writes; frozen while halted and during the restart delay.
`timescale 1ns/1ns
module wdg_prescaler #(
    parameter int PRESC_W = wdg_pkg::PRESC_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic osc_tick,
    input wire logic run,
    input wire logic [1:0] tb,
    output logic period_done
);

    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    logic [wdg_pkg::SLOT_W-1:0] slot_q;
    logic [wdg_pkg::SLOT_W-1:0] slot_d;
    logic [wdg_pkg::SLOT_W-1:0] slot_last;
    logic [PRESC_W-1:0] long_last;
    logic [PRESC_W-1:0] short_last;
    logic [PRESC_W-1:0] period_last;
    logic short_slot;

    // One short period per quarter of the high constant
    assign slot_last = wdg_pkg::SLOT_W'(wdg_pkg::tb_hi(tb) / 4 - 1);
    assign long_last = PRESC_W'(wdg_pkg::TICKS_PER_DEC - 1);
    assign short_last = PRESC_W'((wdg_pkg::SHORT_BASE + wdg_pkg::tb_lo(tb))
        * wdg_pkg::TICK_UNIT - 1);
    assign short_slot = (slot_q >= slot_last);
    assign period_last = short_slot ? short_last : long_last;
    assign period_done = run && osc_tick && (presc_q >= period_last);

    // Next prescaler and slot values
    assign presc_d = period_done ? '0 :
        (run && osc_tick) ? presc_q + 1'b1 : presc_q;
    assign slot_d = !period_done ? slot_q :
        short_slot ? '0 : slot_q + 1'b1;

    // Free running state, no write port reaches it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            presc_q <= '0;
            slot_q <= '0;
        end else begin
            presc_q <= presc_d;
            slot_q <= slot_d;
        end
    end

endmodule : wdg_prescaler

// ==== logic/windowed_watchdog_downcounter.sv ====
// Purpose: Software or strap activated watchdog with a 7-bit downcounter.
// Assumes: Register port and all inputs are synchronous to mclk.
// Notes: reset_out_n must feed the chip reset, which in turn drives rst.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns

module windowed_watchdog_downcounter #(
    parameter int COUNT_W = wdg_pkg::COUNT_W,
    parameter int RESTART_SHORT = wdg_pkg::RESTART_SHORT,
    parameter int RESTART_LONG = wdg_pkg::RESTART_LONG
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic osc_tick,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire wdg_pkg::wdg_cfg_t cfg,
    input wire logic halt_exec,
    input wire logic ext_irq,
    input wire logic rtc_irq,
    output logic halt_enter,
    output logic watchdog_active,
    output logic reset_out_n
);

    // Register state
    logic watchdog_activate_bit_q;
    logic watchdog_activate_bit_d;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // Halt handling state
    wdg_pkg::halt_state_t state_q;
    wdg_pkg::halt_state_t state_d;
    logic active_halt_q;
    logic active_halt_d;
    logic [wdg_pkg::RESTART_W-1:0] restart_q;
    logic [wdg_pkg::RESTART_W-1:0] restart_d;

    // Reset pulse state
    logic [wdg_pkg::PULSE_W-1:0] pulse_q;
    logic [wdg_pkg::PULSE_W-1:0] pulse_d;
    logic reset_n_q;
    logic reset_n_d;

    // Decoded strobes and events
    logic wr_ctrl;
    logic rd_ctrl;
    logic rd_status;
    logic active;
    logic write_active;
    logic period_done;
    logic running;
    logic halt_req;
    logic halt_to_reset;
    logic halt_accept;
    logic halt_dec;
    logic decrement;
    logic rollover;
    logic soft_reset;
    logic fire;
    logic wake_now;
    logic wake_delayed;
    logic restart_done;
    logic pulse_busy;
    logic [7:0] ctrl_view;
    logic [7:0] status_view;
    logic [wdg_pkg::RESTART_W-1:0] restart_len;

    // Address decode of the register port
    assign wr_ctrl = bus_wr && (bus_addr == wdg_pkg::CTRL_ADDR);
    assign rd_ctrl = bus_rd && (bus_addr == wdg_pkg::CTRL_ADDR);
    assign rd_status = bus_rd && (bus_addr == wdg_pkg::STATUS_ADDR);

    // Hardware strap overrides the software activation bit
    assign active = watchdog_activate_bit_q || cfg.hw_watchdog_option;
    assign write_active = active || bus_wdata[wdg_pkg::ACT_BIT];

    // Prescaler runs only in ST_RUN, not while halted or during the restart delay
    assign running = (state_q == wdg_pkg::ST_RUN);

    wdg_prescaler #(
        .PRESC_W(wdg_pkg::PRESC_W)
    ) u_prescaler (
        .mclk(mclk),
        .rst(rst),
        .osc_tick(osc_tick),
        .run(running),
        .tb(cfg.rtc_timebase_select),
        .period_done(period_done)
    );

    // Halt instruction decisions
    assign halt_req = halt_exec && running && !pulse_busy;
    assign halt_to_reset = halt_req && active && cfg.halt_reset_option;
    assign halt_accept = halt_req && !halt_to_reset;
    assign halt_dec = halt_accept && !cfg.rtc_interrupt_enable;

    // A write in the same cycle replaces the decrement entirely
    assign decrement = !wr_ctrl && (period_done || halt_dec);
    assign rollover = decrement && (count_q == wdg_pkg::ROLL_VALUE) && active;
    assign soft_reset = wr_ctrl && write_active
        && !bus_wdata[wdg_pkg::TOP_BIT];
    assign fire = (rollover || soft_reset || halt_to_reset) && !pulse_busy;

    // Activation bit: write only sets it, reset only clears it
    assign watchdog_activate_bit_d = watchdog_activate_bit_q
        || (wr_ctrl && bus_wdata[wdg_pkg::ACT_BIT]);

    // Counter: load on write, otherwise free running decrement
    assign count_d = wr_ctrl ? bus_wdata[COUNT_W-1:0] :
        decrement ? count_q - wdg_pkg::COUNT_ONE : count_q;

    // Wake events out of the two halt flavours
    assign wake_now = (state_q == wdg_pkg::ST_STOPPED) && active_halt_q
        && (ext_irq || rtc_irq);
    assign wake_delayed = (state_q == wdg_pkg::ST_STOPPED) && !active_halt_q
        && ext_irq;
    assign restart_done = (state_q == wdg_pkg::ST_RESTART)
        && (restart_q == '0);
    assign restart_len = cfg.long_restart ?
        wdg_pkg::RESTART_W'(RESTART_LONG - 1) :
        wdg_pkg::RESTART_W'(RESTART_SHORT - 1);

    // Halt state machine, next state
    always_comb begin
        state_d = state_q;
        active_halt_d = active_halt_q;
        restart_d = restart_q;
        case (state_q)
            wdg_pkg::ST_RUN: begin
                if (halt_accept) begin
                    state_d = wdg_pkg::ST_STOPPED;
                    active_halt_d = cfg.rtc_interrupt_enable;
                end
            end
            wdg_pkg::ST_STOPPED: begin
                if (wake_now) begin
                    state_d = wdg_pkg::ST_RUN;
                end else if (wake_delayed) begin
                    state_d = wdg_pkg::ST_RESTART;
                    restart_d = restart_len;
                end
            end
            wdg_pkg::ST_RESTART: begin
                if (restart_done) begin
                    state_d = wdg_pkg::ST_RUN;
                end else begin
                    restart_d = restart_q - 1'b1;
                end
            end
            default: begin
                state_d = wdg_pkg::ST_RUN;
            end
        endcase
    end

    // Reset pulse generator; a second cause during a pulse is absorbed
    assign pulse_busy = !reset_n_q;
    assign pulse_d = fire ? wdg_pkg::PULSE_W'(wdg_pkg::RST_PULSE_CYC - 1) :
        (pulse_busy && pulse_q != '0) ? pulse_q - 1'b1 : pulse_q;
    assign reset_n_d = fire ? 1'b0 :
        (pulse_busy && pulse_q == '0) ? 1'b1 : reset_n_q;

    // Read views; unmapped addresses read as zero
    assign ctrl_view = {watchdog_activate_bit_q, count_q};
    assign status_view = {3'h0, cfg.hw_watchdog_option, pulse_busy,
        (state_q == wdg_pkg::ST_RESTART), (state_q == wdg_pkg::ST_STOPPED),
        active};
    assign rdata_d = rd_ctrl ? ctrl_view :
        rd_status ? status_view : wdg_pkg::READ_IDLE;

    // Control register and read data
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            watchdog_activate_bit_q <= 1'b0;
            count_q <= wdg_pkg::CTRL_RESET[COUNT_W-1:0];
            rdata_q <= wdg_pkg::READ_IDLE;
        end else begin
            watchdog_activate_bit_q <= watchdog_activate_bit_d;
            count_q <= count_d;
            rdata_q <= rdata_d;
        end
    end

    // Halt state registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= wdg_pkg::ST_RUN;
            active_halt_q <= 1'b0;
            restart_q <= '0;
        end else begin
            state_q <= state_d;
            active_halt_q <= active_halt_d;
            restart_q <= restart_d;
        end
    end

    // Reset pulse registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pulse_q <= '0;
            reset_n_q <= 1'b1;
        end else begin
            pulse_q <= pulse_d;
            reset_n_q <= reset_n_d;
        end
    end

    // Outputs
    assign bus_rdata = rdata_q;
    assign reset_out_n = reset_n_q;
    assign watchdog_active = active;
    assign halt_enter = halt_accept;

endmodule : windowed_watchdog_downcounter

// ==== tb/wdg_sva.sv ====
// Purpose: Port checks for the watchdog block.
// Assumes: Bound to windowed_watchdog_downcounter, one clock.
// Notes: Pulse length is counted in helper logic.
`timescale 1ns/1ns
module wdg_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire wdg_pkg::wdg_cfg_t cfg,
    input wire logic halt_exec,
    input wire logic halt_enter,
    input wire logic watchdog_active,
    input wire logic reset_out_n
);
    logic [6:0] low_q;
    // Decoded control writes and mapped reads
    wire ctrl_wr = bus_wr && bus_addr == wdg_pkg::CTRL_ADDR;
    wire map_rd = bus_addr == wdg_pkg::CTRL_ADDR
        || bus_addr == wdg_pkg::STATUS_ADDR;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Low phase length; cleared whenever the output is high
    always_ff @(posedge mclk or posedge rst) begin
        if (rst || reset_out_n) begin
            low_q <= 7'h00;
        end else begin
            low_q <= low_q + 7'h01;
        end
    end
    sequence sw_cause;
        ctrl_wr && bus_wdata[7] && !bus_wdata[6] && reset_out_n;
    endsequence
    sequence pulse_start;
        ##1 !reset_out_n ##1 !reset_out_n;
    endsequence
    sw_reset_a: assert property (sw_cause |-> pulse_start)
        else $error("software reset pulse missing");
    pulse_len_a: assert property ($rose(reset_out_n)
        |-> low_q == 7'(wdg_pkg::RST_PULSE_CYC))
        else $error("reset pulse length wrong");
    halt_reset_a: assert property (halt_exec && watchdog_active
        && cfg.halt_reset_option && reset_out_n
        |-> !halt_enter ##1 !reset_out_n)
        else $error("halt did not reset");
    halt_cause_a: assert property (halt_enter |-> halt_exec)
        else $error("halt entry without halt");
    act_set_a: assert property (ctrl_wr && bus_wdata[7]
        |=> watchdog_active)
        else $error("activation write ignored");
    act_sticky_a: assert property ($past(watchdog_active)
        && !$past(cfg.hw_watchdog_option) |-> watchdog_active)
        else $error("watchdog dropped without reset");
    hw_active_a: assert property (cfg.hw_watchdog_option
        |-> watchdog_active)
        else $error("hardware mode not active");
    unmapped_rd_a: assert property (bus_rd && !map_rd
        |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data outside read slot");
endmodule : wdg_sva

bind windowed_watchdog_downcounter wdg_sva u_wdg_sva (
    .mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cfg(cfg),
    .halt_exec(halt_exec), .halt_enter(halt_enter),
    .watchdog_active(watchdog_active), .reset_out_n(reset_out_n)
);

// ==== tb/tb_windowed_watchdog_downcounter.sv ====
// Purpose: Self-checking bench for the watchdog block.
// Assumes: osc_tick held high gives one tick per clock.
// Notes: The bench replays the chip reset after each pulse.
`timescale 1ns/1ns
module tb_windowed_watchdog_downcounter;
    localparam logic [7:0] CA = wdg_pkg::CTRL_ADDR;
    localparam logic [7:0] SA = wdg_pkg::STATUS_ADDR;
    // Shortest period for timebase 3, low constant 54
    localparam int SHORT_P = (192 + 54) * 64;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic osc_tick = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    wdg_pkg::wdg_cfg_t cfg = '0;
    logic halt_exec = 1'b0;
    logic ext_irq = 1'b0;
    logic rtc_irq = 1'b0;
    logic halt_enter;
    logic watchdog_active;
    logic reset_out_n;
    int bad_count = 0;
    int cmp_count = 0;
    int n;
    logic [7:0] d;

    always #4 mclk = ~mclk;
    // Short restart delays keep the wake-up from halt quick
    windowed_watchdog_downcounter #(
        .RESTART_SHORT(16),
        .RESTART_LONG(32)
    ) u_windowed_watchdog_downcounter (
        .mclk(mclk), .rst(rst), .osc_tick(osc_tick),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cfg(cfg),
        .halt_exec(halt_exec), .ext_irq(ext_irq), .rtc_irq(rtc_irq),
        .halt_enter(halt_enter), .watchdog_active(watchdog_active),
        .reset_out_n(reset_out_n)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1;
        chk(bus_rdata, e);
    endtask : rdc

    task automatic chip_rst();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
    endtask : chip_rst

    // Waits for the pulse, measures it, then replays the chip reset
    task automatic pulse_chk(input int lim, output int w);
        int k;
        w = 0;
        k = 0;
        // Let the launching edge settle so its first low cycle is counted
        #1;
        while (reset_out_n !== 1'b0) begin
            @(posedge mclk);
            #1;
            w++;
            if (w > lim) begin
                bad_count++;
                $display("mismatch at %0t: timeout", $time);
                finish_test();
            end
        end
        while (reset_out_n === 1'b0 && k < 100) begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk(8'(k), 8'(wdg_pkg::RST_PULSE_CYC));
        chip_rst();
    endtask : pulse_chk

    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        void'($urandom(32'hf622));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rdc(CA, wdg_pkg::CTRL_RESET);
        chk({7'h00, watchdog_active}, 8'h00);
        // Random loads with the activation bit clear
        repeat (20) begin
            d = 8'($urandom) & 8'h7f;
            wr(CA, d);
            rdc(CA, d);
            d = 8'($urandom);
            if (d != CA && d != SA) rdc(d, 8'h00);
        end
        chk({7'h00, watchdog_active}, 8'h00);
        // Plain halt: one decrement, stop, wake on external interrupt
        wr(CA, 8'h50);
        @(posedge mclk);
        halt_exec <= 1'b1;
        #1;
        chk({7'h00, halt_enter}, 8'h01);
        @(posedge mclk);
        halt_exec <= 1'b0;
        rdc(CA, 8'h4f);
        rdc(SA, 8'h02);
        @(posedge mclk);
        ext_irq <= 1'b1;
        @(posedge mclk);
        ext_irq <= 1'b0;
        repeat (24) @(posedge mclk);
        rdc(SA, 8'h00);
        // Active halt: no decrement, the oscillator interrupt wakes at once
        @(posedge mclk);
        cfg.rtc_interrupt_enable <= 1'b1;
        wr(CA, 8'h50);
        halt_exec <= 1'b1;
        @(posedge mclk);
        halt_exec <= 1'b0;
        rdc(CA, 8'h50);
        rdc(SA, 8'h02);
        @(posedge mclk);
        rtc_irq <= 1'b1;
        @(posedge mclk);
        rtc_irq <= 1'b0;
        cfg.rtc_interrupt_enable <= 1'b0;
        rdc(SA, 8'h00);
        // Strap mode forces the watchdog on
        cfg.hw_watchdog_option <= 1'b1;
        rdc(SA, 8'h11);
        cfg.hw_watchdog_option <= 1'b0;
        wr(CA, 8'hc5);
        wr(CA, 8'h45);
        rdc(CA, 8'hc5);
        cfg.halt_reset_option <= 1'b1;
        @(posedge mclk);
        halt_exec <= 1'b1;
        @(posedge mclk);
        halt_exec <= 1'b0;
        pulse_chk(4, n);
        cfg.halt_reset_option <= 1'b0;
        rdc(CA, wdg_pkg::CTRL_RESET);
        wr(CA, {2'b10, 6'($urandom)});
        pulse_chk(4, n);
        // Free-running count passes 40h with no pulse while inactive
        cfg.rtc_timebase_select <= 2'h3;
        osc_tick <= 1'b1;
        wr(CA, 8'h41);
        n = 0;
        repeat (34000) begin
            @(posedge mclk);
            if (reset_out_n === 1'b0) n++;
        end
        chk(8'(n), 8'h00);
        rdc(CA, 8'h3f);
        wr(CA, 8'hc1);
        pulse_chk(40000, n);
        chk({7'h00, n >= SHORT_P}, 8'h01);
        chk({7'h00, n <= 2 * wdg_pkg::TICKS_PER_DEC + 2}, 8'h01);
        finish_test();
    end
endmodule : tb_windowed_watchdog_downcounter
